/* File: pkg/cps_pkg.sv */
package cps_pkg;
  // Combined program counter and status word
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic irq_off;
    logic fiq_off;
    logic [23:0] pc;
    logic [1:0] mode;
  } cps_r15_t;

  // Processor mode codes
  localparam logic [1:0] MODE_USER = 2'h0;
  localparam logic [1:0] MODE_FIQ = 2'h1;
  localparam logic [1:0] MODE_IRQ = 2'h2;
  localparam logic [1:0] MODE_SVC = 2'h3;

  // Reset value: supervisor, both interrupts off, pc zero
  localparam logic [31:0] R15_RESET = 32'h0C00_0003;
  // Address exception vector 0x14 as a word address
  localparam logic [23:0] ADDR_EXC_VECTOR = 24'h00_0005;
  // Return offset stored for an address exception
  localparam logic [31:0] ADDR_EXC_LINK_OFFSET = 32'h0000_0004;

  // Instruction field positions
  localparam int COND_LSB = 28;
  localparam int IMM_BIT = 25;
  localparam int OPC_LSB = 21;
  localparam int SET_BIT = 20;
  localparam int RN_LSB = 16;
  localparam int RD_LSB = 12;
  localparam int RM_LSB = 0;
  localparam logic [3:0] REG_PC = 4'hF;
  // Address bits that must be zero for a data access
  localparam int ADDR_HI_LSB = 26;

  // Flag-only operation codes
  localparam logic [1:0] OPC_AND = 2'h0;
  localparam logic [1:0] OPC_XOR = 2'h1;
  localparam logic [1:0] OPC_SUB = 2'h2;
  localparam logic [1:0] OPC_ADD = 2'h3;

  // Kinds of write into the combined register
  typedef enum logic [1:0] {
    CPS_WR_PC = 2'h1,
    CPS_WR_ALL = 2'h2
  } cps_wr_kind_t;

  // Exception causes
  typedef enum logic [2:0] {
    CPS_EXC_ABORT = 3'h0,
    CPS_EXC_UNDEF = 3'h1,
    CPS_EXC_SWI = 3'h2,
    CPS_EXC_IRQ = 3'h3,
    CPS_EXC_FIQ = 3'h4
  } cps_cause_t;

  // Request carriers
  typedef struct packed {
    logic valid;
    cps_wr_kind_t kind;
    logic [31:0] data;
  } cps_wr_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] rn;
    logic [31:0] imm_op;
    logic [31:0] reg_op;
  } cps_fo_req_t;

  typedef struct packed {
    logic valid;
    cps_cause_t cause;
    logic [23:0] vector;
  } cps_exc_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] instr_addr;
  } cps_chk_req_t;

  // Register map
  localparam logic [3:0] OFF_R15 = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_FAULT = 4'h8;
  localparam logic [3:0] OFF_COUNT = 4'hC;
  localparam int CTRL_CHECK_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus channel states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } cps_bus_state_t;
endpackage

/* File: design/cps_r15.sv */
`timescale 1ns/1ps
// Summary of operation
// - Pc held as 24-bit word in bits 25:2
// - Status in bits 31:26 and 1:0
// - Four modes: user, fiq, irq, supervisor
// - Abort and undefined enter supervisor mode
// - User mode cannot write I, F, mode
// - First operand read gives pc bits only
// - Second operand read gives all 32 bits
// - Stores of the register store all bits
// - Link and exceptions other than address exception copy whole register
// - Plain writes update pc, keep status
// - Status-setting writes update pc and status
// - Status returns allowed in user, restricted
// - Destination 0b1111 marks flag-only variants
// - Opcode picks and, xor, subtract, add
// - Flag-only writes status, user only flags
// - Flag-only runs only when condition passes
// - Bit 25 picks immediate or register operand
// - Data address top six bits checked
// - Address exception: link+4, svc, irq off, 0x14
// - Subtract-8 status return restores everything
// - No separate status registers or moves
module cps_r15 (
  input wire logic aclk,
  input wire logic aresetn,
  // Datapath requests
  input wire logic fetch_adv,
  input wire logic rd_valid,
  input wire logic [31:0] rd_instr,
  input wire logic bl_valid,
  input wire cps_pkg::cps_wr_req_t wr_req,
  input wire cps_pkg::cps_fo_req_t fo_req,
  input wire cps_pkg::cps_exc_req_t exc_req,
  input wire cps_pkg::cps_chk_req_t chk_req,
  // Datapath answers
  output cps_pkg::cps_r15_t r15,
  output logic [31:0] rn_value,
  output logic [31:0] rm_value,
  output logic status_move_undef,
  output logic flag_only_hit,
  output logic [31:0] link_value,
  output logic link_load,
  output logic addr_exc,
  // AXI4-Lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // Control register, address checking enable
  logic [31:0] ctrl;
  // Last faulting data address and count of faults
  logic [31:0] fault_addr;
  logic [31:0] fault_count;
  // Bus channel state
  cps_pkg::cps_bus_state_t wst;
  cps_pkg::cps_bus_state_t rst;
  logic aw_got;
  logic w_got;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  // Event selection after priority
  logic sel_addr;
  logic sel_exc;
  logic sel_fo;
  logic sel_wr;
  logic sel_fetch;
  // Flag-only datapath
  logic fo_decoded;
  logic cond_ok;
  logic [31:0] shifter;
  logic [31:0] alu_out;
  logic privileged;
  logic do_write;
  logic [31:0] next_link_addr;

  // Condition check against current flags
  function automatic logic cond_pass(input logic [3:0] cond, input cps_pkg::cps_r15_t s);
    logic res;
    res = 1'b0;
    case (cond[3:1])
      3'h0: res = s.z;
      3'h1: res = s.c;
      3'h2: res = s.n;
      3'h3: res = s.v;
      3'h4: res = s.c && !s.z;
      3'h5: res = (s.n == s.v);
      3'h6: res = !s.z && (s.n == s.v);
      default: res = 1'b1;
    endcase
    // Odd codes invert, except the never code
    if (cond[0] && (cond[3:1] != 3'h7))
    begin
      res = !res;
    end
    else if (cond == 4'hF)
    begin
      res = 1'b0;
    end
    return res;
  endfunction

  // Decode, operand choice, alu and priority
  always_comb
  begin
    privileged = (r15.mode != cps_pkg::MODE_USER);
    // Flag-only form: compare class, set bit, destination all ones
    fo_decoded = (fo_req.instr[27:26] == 2'h0) && (fo_req.instr[24:23] == 2'h2)
      && fo_req.instr[cps_pkg::SET_BIT]
      && (fo_req.instr[cps_pkg::RD_LSB +: 4] == cps_pkg::REG_PC);
    cond_ok = cond_pass(fo_req.instr[cps_pkg::COND_LSB +: 4], r15);
    // Immediate or register shifter operand
    shifter = fo_req.instr[cps_pkg::IMM_BIT] ? fo_req.imm_op : fo_req.reg_op;
    case (fo_req.instr[cps_pkg::OPC_LSB +: 2])
      cps_pkg::OPC_AND: alu_out = fo_req.rn & shifter;
      cps_pkg::OPC_XOR: alu_out = fo_req.rn ^ shifter;
      cps_pkg::OPC_SUB: alu_out = fo_req.rn - shifter;
      default: alu_out = fo_req.rn + shifter;
    endcase
    // Address exception wins, then exceptions, flag-only, writes, fetch
    sel_addr = chk_req.valid && ctrl[cps_pkg::CTRL_CHECK_BIT]
      && (chk_req.addr[31:cps_pkg::ADDR_HI_LSB] != 6'h00);
    sel_exc = !sel_addr && exc_req.valid;
    sel_fo = !sel_addr && !sel_exc && fo_req.valid && fo_decoded && cond_ok;
    sel_wr = !sel_addr && !sel_exc && !sel_fo && wr_req.valid;
    sel_fetch = !sel_addr && !sel_exc && !sel_fo && !sel_wr && fetch_adv;
    next_link_addr = chk_req.instr_addr + cps_pkg::ADDR_EXC_LINK_OFFSET;
    do_write = (wst == cps_pkg::BUS_IDLE) && aw_got && w_got;
  end

  // Combined register update
  // No separate current or saved status copies exist
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r15 <= cps_pkg::R15_RESET;
    end
    else if (sel_addr)
    begin
      // Supervisor, normal interrupts off, vector 0x14
      r15.mode <= cps_pkg::MODE_SVC;
      r15.irq_off <= 1'b1;
      r15.pc <= cps_pkg::ADDR_EXC_VECTOR;
    end
    else if (sel_exc)
    begin
      r15.pc <= exc_req.vector;
      r15.irq_off <= 1'b1;
      // Only fast interrupt entry also masks fast interrupts
      if (exc_req.cause == cps_pkg::CPS_EXC_FIQ)
      begin
        r15.fiq_off <= 1'b1;
        r15.mode <= cps_pkg::MODE_FIQ;
      end
      else if (exc_req.cause == cps_pkg::CPS_EXC_IRQ)
      begin
        r15.mode <= cps_pkg::MODE_IRQ;
      end
      else
      begin
        // Abort, undefined and software traps share supervisor
        r15.mode <= cps_pkg::MODE_SVC;
      end
    end
    else if (sel_fo)
    begin
      // Flags always, pc never
      {r15.n, r15.z, r15.c, r15.v} <= alu_out[31:28];
      if (privileged)
      begin
        {r15.irq_off, r15.fiq_off} <= alu_out[27:26];
        r15.mode <= alu_out[1:0];
      end
    end
    else if (sel_wr)
    begin
      r15.pc <= wr_req.data[25:2];
      if (wr_req.kind == cps_pkg::CPS_WR_ALL)
      begin
        // Status-setting writes and status returns, e.g. subtract 8
        {r15.n, r15.z, r15.c, r15.v} <= wr_req.data[31:28];
        if (privileged)
        begin
          {r15.irq_off, r15.fiq_off} <= wr_req.data[27:26];
          r15.mode <= wr_req.data[1:0];
        end
      end
    end
    else if (sel_fetch)
    begin
      r15.pc <= r15.pc + 24'h00_0001;
    end
  end

  // Operand views of the combined register, one cycle after request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rn_value <= 32'h0000_0000;
      rm_value <= 32'h0000_0000;
      status_move_undef <= 1'b0;
    end
    else
    begin
      // First operand: pc bits only, rest zero
      rn_value <= (rd_valid && rd_instr[cps_pkg::RN_LSB +: 4] == cps_pkg::REG_PC)
        ? {6'h00, r15.pc, 2'h0} : 32'h0000_0000;
      // Second operand and stores: whole word
      rm_value <= (rd_valid && rd_instr[cps_pkg::RM_LSB +: 4] == cps_pkg::REG_PC)
        ? r15 : 32'h0000_0000;
      // Status move encodings are refused as undefined
      status_move_undef <= rd_valid
        && (((rd_instr[27:23] == 5'h02) && !rd_instr[cps_pkg::SET_BIT]
        && (rd_instr[7:4] != 4'h9))
        || ((rd_instr[27:23] == 5'h06) && (rd_instr[21:20] == 2'h2)));
    end
  end

  // Link capture and event pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_value <= 32'h0000_0000;
      link_load <= 1'b0;
      addr_exc <= 1'b0;
      flag_only_hit <= 1'b0;
    end
    else
    begin
      link_load <= sel_addr || sel_exc || bl_valid;
      addr_exc <= sel_addr;
      flag_only_hit <= sel_fo;
      if (sel_addr)
      begin
        // Return point is faulting instruction address plus 4, status kept
        link_value <= {r15[31:26], next_link_addr[25:2], r15.mode};
      end
      else if (sel_exc || bl_valid)
      begin
        link_value <= r15;
      end
    end
  end

  // Fault address capture and count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_addr <= 32'h0000_0000;
      fault_count <= 32'h0000_0000;
    end
    else if (sel_addr)
    begin
      fault_addr <= chk_req.addr;
      fault_count <= fault_count + 32'h0000_0001;
    end
  end

  // Control register write, low byte lane only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= cps_pkg::CTRL_RESET;
    end
    else if (do_write && (awaddr_q == cps_pkg::OFF_CTRL) && wstrb_q[0])
    begin
      ctrl <= {31'h0000_0000, wdata_q[cps_pkg::CTRL_CHECK_BIT]};
    end
  end

  // Write address and data channels, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wst <= cps_pkg::BUS_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= cps_pkg::RESP_OKAY;
    end
    else
    begin
      case (wst)
        cps_pkg::BUS_IDLE:
        begin
          if (s_awvalid && s_awready)
          begin
            aw_got <= 1'b1;
            awaddr_q <= s_awaddr;
            s_awready <= 1'b0;
          end
          else if (!aw_got)
          begin
            s_awready <= 1'b1;
          end
          if (s_wvalid && s_wready)
          begin
            w_got <= 1'b1;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
            s_wready <= 1'b0;
          end
          else if (!w_got)
          begin
            s_wready <= 1'b1;
          end
          // Both halves held: answer
          if (do_write)
          begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b1;
            // Only the control word is writable
            s_bresp <= (awaddr_q == cps_pkg::OFF_CTRL) ? cps_pkg::RESP_OKAY
              : cps_pkg::RESP_SLVERR;
            wst <= cps_pkg::BUS_RESP;
          end
        end
        cps_pkg::BUS_RESP:
        begin
          if (s_bready)
          begin
            s_bvalid <= 1'b0;
            wst <= cps_pkg::BUS_IDLE;
          end
        end
        default:
        begin
          wst <= cps_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst <= cps_pkg::BUS_IDLE;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= cps_pkg::RESP_OKAY;
    end
    else
    begin
      case (rst)
        cps_pkg::BUS_IDLE:
        begin
          if (s_arvalid && s_arready)
          begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= cps_pkg::RESP_OKAY;
            rst <= cps_pkg::BUS_RESP;
            case (s_araddr)
              cps_pkg::OFF_R15: s_rdata <= r15;
              cps_pkg::OFF_CTRL: s_rdata <= ctrl;
              cps_pkg::OFF_FAULT: s_rdata <= fault_addr;
              cps_pkg::OFF_COUNT: s_rdata <= fault_count;
              default:
              begin
                s_rdata <= 32'h0000_0000;
                s_rresp <= cps_pkg::RESP_SLVERR;
              end
            endcase
          end
          else
          begin
            s_arready <= 1'b1;
          end
        end
        cps_pkg::BUS_RESP:
        begin
          if (s_rready)
          begin
            s_rvalid <= 1'b0;
            rst <= cps_pkg::BUS_IDLE;
          end
        end
        default:
        begin
          rst <= cps_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fetch_pc_a: assert property (sel_fetch |=> r15.pc == $past(r15.pc) + 24'h00_0001
    && r15[31:26] == $past(r15[31:26]) && r15.mode == $past(r15.mode))
    else $error("fetch did not advance pc alone");
  rn_mask_a: assert property (rd_valid && rd_instr[19:16] == 4'hF
    |=> rn_value == {6'h00, $past(r15.pc), 2'h0})
    else $error("first operand not masked");
  rm_full_a: assert property (rd_valid && rd_instr[3:0] == 4'hF |=> rm_value == $past(r15))
    else $error("second operand not full word");
  user_lock_a: assert property (sel_wr && r15.mode == cps_pkg::MODE_USER
    |=> r15.mode == cps_pkg::MODE_USER && $stable(r15.irq_off) && $stable(r15.fiq_off))
    else $error("user write changed protected bits");
  pc_only_a: assert property (sel_wr && wr_req.kind == cps_pkg::CPS_WR_PC
    |=> $stable(r15[31:26]) && $stable(r15.mode) && r15.pc == $past(wr_req.data[25:2]))
    else $error("pc-only write touched status");
  abort_svc_a: assert property (sel_exc && exc_req.cause inside {cps_pkg::CPS_EXC_ABORT,
    cps_pkg::CPS_EXC_UNDEF} |=> r15.mode == cps_pkg::MODE_SVC && link_load)
    else $error("abort did not enter supervisor");
  addr_exc_a: assert property (sel_addr |=> addr_exc && r15.mode == cps_pkg::MODE_SVC
    && r15.irq_off && r15.pc == 24'h00_0005
    && link_value[25:2] == $past(next_link_addr[25:2]))
    else $error("address exception entry wrong");
  flag_pc_a: assert property (sel_fo |=> $stable(r15.pc) && flag_only_hit
    && r15[31:28] == $past(alu_out[31:28]))
    else $error("flag-only write wrong");
  cond_fail_a: assert property (fo_req.valid && fo_decoded && !cond_ok && !sel_addr
    && !sel_exc && !wr_req.valid && !fetch_adv |=> $stable(r15) ##0 !flag_only_hit)
    else $error("failed condition had an effect");
  link_full_a: assert property (sel_exc |=> link_load && link_value == $past(r15))
    else $error("link not whole register");

  addr_exc_c: cover property (sel_addr ##1 addr_exc);
  priv_mode_c: cover property (sel_fo && privileged && alu_out[1:0] == cps_pkg::MODE_USER);
  user_return_c: cover property (sel_wr && !privileged && wr_req.kind == cps_pkg::CPS_WR_ALL);
endmodule

/* File: test/cps_dp_model.sv */
`timescale 1ns/1ps
// Datapath, decoder and exception side: one-cycle requests launched after an edge
module cps_dp_model (
  input wire logic aclk,
  output logic fetch_adv,
  output logic rd_valid,
  output logic [31:0] rd_instr,
  output logic bl_valid,
  output cps_pkg::cps_wr_req_t wr_req,
  output cps_pkg::cps_fo_req_t fo_req,
  output cps_pkg::cps_exc_req_t exc_req,
  output cps_pkg::cps_chk_req_t chk_req
);
  // Known payloads at time zero
  initial
  begin
    rd_instr = 32'h0;
    wr_req = '0;
    fo_req = '0;
    exc_req = '0;
    chk_req = '0;
    idle();
  end

  // Drop every valid; payloads other than kind and cause flip so a stale value never looks current
  task idle();
    fetch_adv <= 1'b0;
    rd_valid <= 1'b0;
    bl_valid <= 1'b0;
    rd_instr <= ~rd_instr;
    wr_req <= {1'b0, wr_req.kind, ~wr_req.data};
    fo_req <= {1'b0, ~fo_req[127:0]};
    exc_req <= {1'b0, exc_req.cause, ~exc_req.vector};
    chk_req <= {1'b0, ~chk_req[63:0]};
  endtask

  // Request stands exactly one cycle
  task fin();
    @(posedge aclk);
    idle();
  endtask

  // Sequential fetch step
  task fetch();
    @(posedge aclk);
    fetch_adv <= 1'b1;
    fin();
  endtask

  // Operand read of one instruction
  task rd(input logic [31:0] i);
    @(posedge aclk);
    rd_valid <= 1'b1;
    rd_instr <= i;
    fin();
  endtask

  // Branch with link
  task bl();
    @(posedge aclk);
    bl_valid <= 1'b1;
    fin();
  endtask

  // Write into the combined register
  task wr(input cps_pkg::cps_wr_kind_t k, input logic [31:0] v);
    @(posedge aclk);
    wr_req <= '{valid: 1'b1, kind: k, data: v};
    fin();
  endtask

  // Flag-only candidate with its operands
  task fo(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] c);
    @(posedge aclk);
    fo_req <= '{valid: 1'b1, instr: i, rn: a, imm_op: b, reg_op: c};
    fin();
  endtask

  // Exception entry
  task exc(input cps_pkg::cps_cause_t c, input logic [23:0] v);
    @(posedge aclk);
    exc_req <= '{valid: 1'b1, cause: c, vector: v};
    fin();
  endtask

  // Data address offered for checking
  task chk(input logic [31:0] a, input logic [31:0] ia);
    @(posedge aclk);
    chk_req <= '{valid: 1'b1, addr: a, instr_addr: ia};
    fin();
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench: datapath model plus AXI4-Lite master tasks
module testbench;
  // Clock, reset and bus master drive
  logic aclk;
  logic aresetn = 1'b0;
  logic [3:0] s_awaddr = 4'h0;
  logic s_awvalid = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic [3:0] s_araddr = 4'h0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  // Datapath requests and design answers
  logic fetch_adv, rd_valid, bl_valid;
  logic [31:0] rd_instr;
  cps_pkg::cps_wr_req_t wr_req;
  cps_pkg::cps_fo_req_t fo_req;
  cps_pkg::cps_exc_req_t exc_req;
  cps_pkg::cps_chk_req_t chk_req;
  cps_pkg::cps_r15_t r15;
  logic [31:0] rn_value, rm_value, link_value, s_rdata;
  logic status_move_undef, flag_only_hit, link_load, addr_exc;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  // Scoreboard
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] ex, d, ins, lk, a1, a2, a3;
  logic [1:0] r;

  cps_dp_model dp_u (.aclk, .fetch_adv, .rd_valid, .rd_instr, .bl_valid, .wr_req,
    .fo_req, .exc_req, .chk_req);
  cps_r15 dut_u (.aclk, .aresetn, .fetch_adv, .rd_valid, .rd_instr, .bl_valid, .wr_req,
    .fo_req, .exc_req, .chk_req, .r15, .rn_value, .rm_value, .status_move_undef,
    .flag_only_hit, .link_value, .link_load, .addr_exc, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready);

  // 50 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Counted compare
  task cmp(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      err_total++;
    end
  endtask

  // Settled view of the combined register
  task chk_r15();
    @(negedge aclk);
    cmp(r15, ex);
  endtask

  // Bus write: address and data offered together, bready held until bvalid
  task axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask

  // Bus read: rready held until rvalid
  task axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask

  // Flag-only arithmetic
  function automatic logic [31:0] alu_f(input logic [1:0] o, input logic [31:0] a,
    input logic [31:0] b);
    case (o)
      2'h0: return a & b;
      2'h1: return a ^ b;
      2'h2: return a - b;
      default: return a + b;
    endcase
  endfunction

  // Register after a write of either kind
  function automatic logic [31:0] wr_f(input logic [31:0] e, input logic all,
    input logic [31:0] v);
    if (!all) return {e[31:26], v[25:2], e[1:0]};
    if (e[1:0] == cps_pkg::MODE_USER) return {v[31:28], e[27:26], v[25:2], e[1:0]};
    return v;
  endfunction

  // Register after a flag-only result
  function automatic logic [31:0] fo_f(input logic [31:0] e, input logic [31:0] v);
    if (e[1:0] == cps_pkg::MODE_USER) return {v[31:28], e[27:0]};
    return {v[31:26], e[25:2], v[1:0]};
  endfunction

  // Verdict and end of run
  task print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: tests need well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    err_total++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h9F2B05C8));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    ex = cps_pkg::R15_RESET;
    chk_r15();
    axi_rd(4'h0, d, r);
    cmp(d, ex);
    axi_rd(4'h4, d, r);
    cmp(d, cps_pkg::CTRL_RESET);
    axi_rd(4'h2, d, r);
    cmp({30'h0, r}, {30'h0, cps_pkg::RESP_SLVERR});
    axi_wr(4'h0, 32'h0, r);
    cmp({30'h0, r}, {30'h0, cps_pkg::RESP_SLVERR});
    chk_r15();
    $display("test reset done");
    // Writes of both kinds, then fetch wrap
    d = $urandom | 32'h3;
    dp_u.wr(cps_pkg::CPS_WR_ALL, d);
    ex = wr_f(ex, 1'b1, d);
    chk_r15();
    d = $urandom;
    dp_u.wr(cps_pkg::CPS_WR_PC, d);
    ex = wr_f(ex, 1'b0, d);
    chk_r15();
    dp_u.wr(cps_pkg::CPS_WR_PC, 32'h03FF_FFFC);
    dp_u.fetch();
    ex = {ex[31:26], 24'h0, ex[1:0]};
    chk_r15();
    $display("test writes done");
    // Operand reads, status move, link
    dp_u.rd(32'hE08F_000F);
    @(negedge aclk);
    cmp(rn_value, {6'h0, ex[25:2], 2'h0});
    cmp(rm_value, ex);
    dp_u.rd(32'hE10F_0000);
    @(negedge aclk);
    cmp({31'h0, status_move_undef}, 32'h1);
    cmp(rm_value, 32'h0);
    dp_u.bl();
    @(negedge aclk);
    cmp(link_value, ex);
    cmp({31'h0, link_load}, 32'h1);
    // Fast then normal interrupt entry
    lk = ex;
    dp_u.exc(cps_pkg::CPS_EXC_FIQ, 24'h7);
    ex = {ex[31:28], 2'h3, 24'h7, cps_pkg::MODE_FIQ};
    chk_r15();
    cmp(link_value, lk);
    dp_u.exc(cps_pkg::CPS_EXC_IRQ, 24'h6);
    ex = {ex[31:28], 1'b1, ex[26], 24'h6, cps_pkg::MODE_IRQ};
    chk_r15();
    $display("test reads done");
    // Flag-only ops, every code, privileged then user
    for (int i = 0; i < 8; i++)
    begin
      lk = ex;
      dp_u.exc((i[0] ? cps_pkg::CPS_EXC_UNDEF : cps_pkg::CPS_EXC_ABORT), 24'h3);
      ex = {ex[31:28], 1'b1, ex[26], 24'h3, 2'h3};
      @(negedge aclk);
      cmp(link_value, lk);
      if (i > 3)
      begin
        d = $urandom & 32'hFFFF_FFFC;
        dp_u.wr(cps_pkg::CPS_WR_ALL, d);
        ex = wr_f(ex, 1'b1, d);
      end
      chk_r15();
      ins = {4'hE, 2'h0, 1'($urandom), 2'h2, i[1:0], 1'b1, 4'h0, 4'hF, 12'h0};
      a1 = $urandom;
      a2 = $urandom;
      a3 = $urandom;
      dp_u.fo(ins, a1, a2, a3);
      ex = fo_f(ex, alu_f(i[1:0], a1, ins[25] ? a2 : a3));
      chk_r15();
      cmp({31'h0, flag_only_hit}, 32'h1);
    end
    d = ~ex;
    dp_u.wr(cps_pkg::CPS_WR_ALL, d);
    ex = wr_f(ex, 1'b1, d);
    chk_r15();
    ins = {3'h0, ex[30], 2'h0, 1'b0, 2'h2, 2'h3, 1'b1, 4'h0, 4'hF, 12'h0};
    dp_u.fo(ins, 32'hFFFF_FFFF, 32'h0, 32'h0);
    chk_r15();
    cmp({31'h0, flag_only_hit}, 32'h0);
    $display("test flag_only done");
    // Address exception from user mode and return
    d = 32'h0400_0000 | $urandom;
    a1 = ($urandom & 32'h03FF_FFFC) | 32'h10;
    dp_u.chk(d, a1);
    lk = a1 + 32'h4;
    lk = {ex[31:26], lk[25:2], ex[1:0]};
    ex = {ex[31:28], 1'b1, ex[26], 24'h5, 2'h3};
    chk_r15();
    cmp({31'h0, addr_exc}, 32'h1);
    cmp(link_value, lk);
    axi_rd(4'h8, a2, r);
    cmp(a2, d);
    dp_u.wr(cps_pkg::CPS_WR_ALL, lk - 32'h8);
    ex = lk - 32'h8;
    chk_r15();
    dp_u.chk(32'h03FF_FFFF, a1);
    chk_r15();
    cmp({31'h0, addr_exc}, 32'h0);
    axi_wr(4'h4, 32'h0, r);
    cmp({30'h0, r}, {30'h0, cps_pkg::RESP_OKAY});
    dp_u.chk(32'hFC00_0000, a1);
    chk_r15();
    cmp({31'h0, addr_exc}, 32'h0);
    $display("test address_check done");
    print_verdict();
  end
endmodule
